// ==== src/phase_mgr_defs.vh ====
// Functional notes
// R01: One or two rails share four stages; reject rail two larger or rail one empty.
// R02: Stages fill in order 1A,1B,2A,3A; 3:1 gives 2A to rail two.
// R03: Rail two first stage lags by 3/13 of the fastest rail period.
// R04: Stages on one rail start period divided by stage count apart.
// R05: Sync input rising edge restarts period counter of each following rail.
// R06: Restart mid-pulse lengthens it; finished pulse gets a second one.
// R07: Sync word upper byte picks pulse output driving sync out; else disabled.
// R08: Sync word lower byte is per-rail follow mask, several bits allowed.
// R09: After an external sync that a rail follows, rail spacing stays off until soft reset.
// R10: Shedding on and rail current under low limit drops configured stages.
// R11: Optionally select light-load coefficient bank on entering light load.
// R12: Current above high limit re-enables all stages and normal bank.
// R13: Channels converted in turn by shared 12-bit converter; A channels get thresholds.
// R14: One rail current sampled per 200 us slot.
// R15: Each sample smoothed by first-order filter, time constant about 3.5 samples.
// R16: Smoothed current beyond over or under limit declares fault and recovery.
// R17: Raw sample scaled by per-channel gain and offset before smoothing.
// R18: Readback gives averaged current, summed over the stages of a rail.
// R19: All rails run from one common clock, no internal sync.
// R20: Bank two under light load, bank one regulating, bank zero ramping.
// R21: Selected output gives one-cycle sync out pulse at each period start.
`ifndef PHASE_MGR_DEFS_VH
`define PHASE_MGR_DEFS_VH
`define A_STAGE_CFG  8'h00
`define A_PERIOD     8'h04
`define A_DUTY       8'h08
`define A_SYNC_CFG   8'h0C
`define A_LL_LIMIT   8'h10
`define A_LL_CFG     8'h14
`define A_CUR_LIMIT  8'h18
`define A_CAL_GAIN   8'h1C
`define A_CAL_OFS    8'h20
`define A_FAST_OC    8'h24
`define A_CTRL       8'h28
`define A_STATUS     8'h2C
`define A_IOUT       8'h30
`define A_SOFT_RST   8'h34
`define RST_STAGE_CFG 32'h0000_0004
`define RST_PERIOD    32'h0064_0064
`define RST_DUTY      32'h0020_0020
`define RST_SYNC_CFG  16'hFF00
`define RST_LL_LIMIT  32'h0200_0100
`define RST_CUR_LIMIT 32'h0000_F000
`define RST_CAL_GAIN  32'h1010_1010
`define ST_FAULT_LSB  0
`define ST_LL_LSB     2
`define ST_SYNC_SEEN  4
`define ST_CFG_ERR    5
`define CLK_NS        100
`define SLOT_US       200
`define SLOT_CYC      ((`SLOT_US * 1000) / `CLK_NS)
`define SPREAD_NUM    3
`define SPREAD_DEN    13
`define CAL_SHIFT     4
`define FILT_SHIFT    2
`endif

// ==== src/multiphase_pwm_phase_manager.v ====
`timescale 1ns/1ps
`include "phase_mgr_defs.vh"
module multiphase_pwm_phase_manager #(
  parameter NCH = 4,
  parameter PW  = 16
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          sync_in,
  output reg           sync_out,
  output reg  [NCH-1:0] pulse_output,
  output reg           adc_start,
  output reg  [1:0]    adc_chan,
  input  wire          adc_valid,
  input  wire [11:0]   adc_data,
  output reg  [3:0]    coef_bank,
  output reg  [17:0]   fast_oc_thresh
);
  localparam S_IDLE = 2'd0;
  localparam S_ISSUE = 2'd1;
  localparam S_WAIT = 2'd2;
  localparam S_EVAL = 2'd3;
  localparam integer SLOT_FULL = `SLOT_CYC;
  localparam [11:0] SLOT_CYC = SLOT_FULL[11:0];

  reg  [2:0]   n1_r, n2_r;
  reg  [31:0]  period_r, duty_r, ll_lim_r, ll_cfg_r, cur_lim_r, gain_r, ofs_r, ctrl_r;
  reg  [15:0]  sync_cfg_r;
  reg  [1:0]   fault_r, ll_r;
  reg          sync_seen_r, cfg_err_r, sync_d_r;
  reg  [PW-1:0] cnt_r [0:1];
  reg  [15:0]  avg_r [0:NCH-1];
  reg  [15:0]  iout_r [0:1];
  reg  [11:0]  slot_r;
  reg  [1:0]   st_r, ch_r;
  reg          rs_r;
  reg  [11:0]  raw_r;
  reg          upd_r;
  reg  [1:0]   uch_r;

  wire         acc  = psel & penable & pready;
  wire         wr   = acc & pwrite;
  wire         two  = (n2_r != 3'd0);
  wire         sync_rise = sync_in & ~sync_d_r;
  wire [2:0]   wn1  = pwdata[2:0];
  wire [2:0]   wn2  = pwdata[6:4];
  wire [3:0]   wsum = {1'b0, wn1} + {1'b0, wn2};
  wire         cfg_ok = (wn1 != 3'd0) && (wn2 <= wn1) && (wsum <= 4'd4); // R01

  // Stage to rail mapping
  reg [NCH-1:0] ch_en, ch_rail;
  reg [1:0]     ch_pos [0:NCH-1];
  integer k;
  integer km;
  always @* begin
    for (km = 0; km < NCH; km = km + 1) begin
      ch_en[km] = 1'b0;
      ch_rail[km] = 1'b0;
      ch_pos[km] = 2'd0;
    end
    if (!two) begin // R02
      for (km = 0; km < NCH; km = km + 1) begin
        ch_en[km] = (km < n1_r);
        ch_pos[km] = km[1:0];
      end
    end else begin // R02
      ch_en[0] = 1'b1;
      ch_en[1] = (n1_r >= 3'd2);
      ch_pos[1] = 2'd1;
      ch_en[2] = 1'b1;
      ch_rail[2] = 1'b1;
      ch_en[3] = 1'b1;
      if (n1_r == 3'd3) begin
        ch_pos[3] = 2'd2;
      end else begin
        ch_en[3] = (n2_r == 3'd2);
        ch_rail[3] = 1'b1;
        ch_pos[3] = 2'd1;
      end
    end
  end

  // Effective stage count after shedding
  reg [2:0] neff [0:1];
  reg [2:0] ncfg, shed;
  integer r;
  integer rr;
  always @* begin
    for (rr = 0; rr < 2; rr = rr + 1) begin
      ncfg = (rr == 0) ? n1_r : n2_r;
      shed = {1'b0, ll_cfg_r[2*rr+3 -: 2]};
      neff[rr] = ncfg;
      if (ll_r[rr] && ll_cfg_r[0]) begin // R10
        neff[rr] = (shed < ncfg) ? ncfg - shed : 3'd1;
      end
    end
  end

  wire [PW-1:0] per0 = period_r[PW-1:0];
  wire [PW-1:0] per1 = period_r[PW+15:16];
  wire [PW-1:0] pmin = (two && per1 < per0) ? per1 : per0;
  wire [31:0]   pmin_w = {{(32-PW){1'b0}}, pmin};
  wire [31:0]   spr_w = (pmin_w * `SPREAD_NUM) / `SPREAD_DEN; // R03
  wire [PW-1:0] spread = (two && !sync_seen_r) ? spr_w[PW-1:0] : {PW{1'b0}}; // R09
  wire [1:0]    shut = fault_r & {2{~ctrl_r[2]}}; // R16

  // Per-stage pulse generation
  reg [NCH-1:0] pulse_nxt, start_nxt;
  reg [PW+1:0]  off;
  reg [PW:0]    off1, t;
  reg [PW-1:0]  per, cnt, dty;
  reg           rl;
  integer c;
  always @* begin
    for (c = 0; c < NCH; c = c + 1) begin
      rl = ch_rail[c];
      per = rl ? per1 : per0;
      dty = rl ? duty_r[PW+15:16] : duty_r[PW-1:0];
      cnt = cnt_r[rl];
      off = ({2'd0, per} * ch_pos[c]) / neff[rl]; // R04
      off1 = off[PW:0] + (rl ? {1'b0, spread} : {(PW+1){1'b0}}); // R03
      if (off1 >= {1'b0, per}) begin
        off1 = off1 - {1'b0, per};
      end
      if ({1'b0, cnt} >= off1) begin
        t = {1'b0, cnt} - off1;
      end else begin
        t = {1'b0, cnt} + {1'b0, per} - off1;
      end
      start_nxt[c] = ch_en[c] && (t == {(PW+1){1'b0}});
      pulse_nxt[c] = ch_en[c] && (ch_pos[c] < neff[rl]) && !shut[rl]
                     && (t < {1'b0, dty}); // R06 R10 R16
    end
  end

  wire [7:0] so_sel = sync_cfg_r[15:8];

  // Current calibration
  wire [1:0]  cch  = uch_r;
  wire [7:0]  cg   = gain_r[8*cch +: 8];
  wire [7:0]  co   = ofs_r[8*cch +: 8];
  wire [19:0] prod = raw_r * cg; // R17
  wire [17:0] cal  = {2'd0, prod[19:`CAL_SHIFT]} + {{10{co[7]}}, co}; // R17
  wire [15:0] amps = cal[17] ? 16'h0000 : (cal[16] ? 16'hFFFF : cal[15:0]);
  wire [15:0] ya   = avg_r[cch];
  wire [16:0] dif  = {1'b0, amps} - {1'b0, ya};
  wire [16:0] stp  = {{`FILT_SHIFT{dif[16]}}, dif[16:`FILT_SHIFT]};
  wire [16:0] ynew = {1'b0, ya} + stp; // R15

  reg [17:0] rsum;
  integer s;
  always @* begin
    rsum = 18'd0;
    for (s = 0; s < NCH; s = s + 1) begin
      if (ch_en[s] && (ch_rail[s] == rs_r)) begin
        rsum = rsum + {2'd0, avg_r[s]}; // R18
      end
    end
  end
  wire [15:0] rcur = rsum[17:16] != 2'd0 ? 16'hFFFF : rsum[15:0];
  wire        chm  = ch_en[ch_r] && (ch_rail[ch_r] == rs_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n1_r <= 3'd4;
      n2_r <= 3'd0;
      period_r <= `RST_PERIOD;
      duty_r <= `RST_DUTY;
      sync_cfg_r <= `RST_SYNC_CFG;
      ll_lim_r <= `RST_LL_LIMIT;
      ll_cfg_r <= 32'h0000_0000;
      cur_lim_r <= `RST_CUR_LIMIT;
      gain_r <= `RST_CAL_GAIN;
      ofs_r <= 32'h0000_0000;
      ctrl_r <= 32'h0000_0000;
      fast_oc_thresh <= 18'h3_FFFF;
      fault_r <= 2'b00;
      ll_r <= 2'b00;
      sync_seen_r <= 1'b0;
      cfg_err_r <= 1'b0;
      sync_d_r <= 1'b0;
      cnt_r[0] <= {PW{1'b0}};
      cnt_r[1] <= {PW{1'b0}};
      for (k = 0; k < NCH; k = k + 1) begin
        avg_r[k] <= 16'h0000;
      end
      iout_r[0] <= 16'h0000;
      iout_r[1] <= 16'h0000;
      slot_r <= 12'd0;
      st_r <= S_IDLE;
      ch_r <= 2'd0;
      rs_r <= 1'b0;
      raw_r <= 12'd0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      sync_out <= 1'b0;
      pulse_output <= {NCH{1'b0}};
      adc_start <= 1'b0;
      adc_chan <= 2'd0;
      coef_bank <= 4'h0;
    end else begin
      // APB slave, answer in first access cycle
      pready <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        case (paddr)
          `A_STAGE_CFG: prdata <= {25'd0, n2_r, 1'b0, n1_r};
          `A_PERIOD:    prdata <= period_r;
          `A_DUTY:      prdata <= duty_r;
          `A_SYNC_CFG:  prdata <= {16'd0, sync_cfg_r};
          `A_LL_LIMIT:  prdata <= ll_lim_r;
          `A_LL_CFG:    prdata <= ll_cfg_r;
          `A_CUR_LIMIT: prdata <= cur_lim_r;
          `A_CAL_GAIN:  prdata <= gain_r;
          `A_CAL_OFS:   prdata <= ofs_r;
          `A_FAST_OC:   prdata <= {14'd0, fast_oc_thresh};
          `A_CTRL:      prdata <= ctrl_r;
          `A_STATUS:    prdata <= {26'd0, cfg_err_r, sync_seen_r, ll_r, fault_r};
          `A_IOUT:      prdata <= {iout_r[1], iout_r[0]}; // R18
          `A_SOFT_RST:  prdata <= 32'h0000_0000;
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
        if (pwrite && paddr == `A_STAGE_CFG && !cfg_ok) begin
          pslverr <= 1'b1; // R01
        end
      end
      if (wr) begin
        case (paddr)
          `A_STAGE_CFG: begin
            if (cfg_ok) begin // R01
              n1_r <= wn1;
              n2_r <= wn2;
            end
          end
          `A_PERIOD:    period_r <= pwdata;
          `A_DUTY:      duty_r <= pwdata;
          `A_SYNC_CFG:  sync_cfg_r <= pwdata[15:0]; // R07 R08
          `A_LL_LIMIT:  ll_lim_r <= pwdata;
          `A_LL_CFG:    ll_cfg_r <= pwdata;
          `A_CUR_LIMIT: cur_lim_r <= pwdata;
          `A_CAL_GAIN:  gain_r <= pwdata;
          `A_CAL_OFS:   ofs_r <= pwdata;
          `A_FAST_OC:   fast_oc_thresh <= pwdata[17:0]; // R13
          `A_CTRL:      ctrl_r <= pwdata;
          default: begin
          end
        endcase
      end
      // Status flags, set wins over clear
      if (wr && paddr == `A_STATUS) begin
        fault_r <= fault_r & ~pwdata[1:0];
        cfg_err_r <= cfg_err_r & ~pwdata[`ST_CFG_ERR];
      end
      if (wr && paddr == `A_STAGE_CFG && !cfg_ok) begin
        cfg_err_r <= 1'b1;
      end
      // Period counters on one clock
      sync_d_r <= sync_in;
      for (r = 0; r < 2; r = r + 1) begin
        if (sync_rise && sync_cfg_r[r]) begin
          cnt_r[r] <= {PW{1'b0}}; // R05 R08
        end else if (cnt_r[r] + 1'b1 >= (r == 0 ? per0 : per1)) begin
          cnt_r[r] <= {PW{1'b0}}; // R19
        end else begin
          cnt_r[r] <= cnt_r[r] + 1'b1;
        end
      end
      if (wr && paddr == `A_SOFT_RST && pwdata[0]) begin
        sync_seen_r <= 1'b0; // R09
        ll_r <= 2'b00;
      end
      if (sync_rise && (sync_cfg_r[1:0] != 2'b00)) begin
        sync_seen_r <= 1'b1; // R09
      end
      pulse_output <= pulse_nxt;
      sync_out <= (so_sel < 8'd4) && start_nxt[so_sel[1:0]]; // R07 R21
      for (r = 0; r < 2; r = r + 1) begin
        if (ctrl_r[r]) begin
          coef_bank[2*r +: 2] <= 2'd0; // R20
        end else if (ll_r[r] && ll_cfg_r[1]) begin
          coef_bank[2*r +: 2] <= 2'd2; // R11 R20
        end else begin
          coef_bank[2*r +: 2] <= 2'd1; // R12 R20
        end
      end
      // Current sampling, one rail per slot
      adc_start <= 1'b0;
      slot_r <= (slot_r == SLOT_CYC - 12'd1) ? 12'd0 : slot_r + 12'd1; // R14
      case (st_r)
        S_IDLE: begin
          if (slot_r == SLOT_CYC - 12'd1) begin
            rs_r <= two ? ~rs_r : 1'b0; // R14
            ch_r <= 2'd0;
            st_r <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (chm) begin
            adc_start <= 1'b1; // R13
            adc_chan <= ch_r;
            st_r <= S_WAIT;
          end else if (ch_r == 2'd3) begin
            st_r <= S_EVAL;
          end else begin
            ch_r <= ch_r + 2'd1;
          end
        end
        S_WAIT: begin
          if (adc_valid) begin
            raw_r <= adc_data;
            st_r <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (!upd_r) begin
            st_r <= S_IDLE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
      if (st_r == S_WAIT && adc_valid) begin
        st_r <= (ch_r == 2'd3) ? S_EVAL : S_ISSUE;
        ch_r <= (ch_r == 2'd3) ? ch_r : ch_r + 2'd1;
        raw_r <= adc_data;
      end
      // Filter update one cycle after capture
      if (upd_r) begin
        avg_r[uch_r] <= ynew[15:0]; // R15
      end
      if (st_r == S_EVAL && !upd_r) begin
        iout_r[rs_r] <= rcur; // R18
        if (rcur > cur_lim_r[15:0] || rcur < cur_lim_r[31:16]) begin
          fault_r[rs_r] <= 1'b1; // R16
        end
        if (ll_cfg_r[0] && rcur < ll_lim_r[15:0]) begin
          ll_r[rs_r] <= 1'b1; // R10
        end else if (rcur > ll_lim_r[31:16]) begin
          ll_r[rs_r] <= 1'b0; // R12
        end
      end
      if (wr && paddr == `A_SOFT_RST && pwdata[0]) begin
        for (k = 0; k < NCH; k = k + 1) begin
          avg_r[k] <= 16'h0000;
        end
      end
    end
  end

  // Pending filter update
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_r <= 1'b0;
      uch_r <= 2'd0;
    end else begin
      upd_r <= (st_r == S_WAIT) && adc_valid;
      uch_r <= ch_r;
    end
  end
endmodule // multiphase_pwm_phase_manager

// ==== sim/phase_mgr_asserts.sv ====
`timescale 1ns/1ps
module phase_mgr_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sync_out,
  input wire        adc_start,
  input wire [3:0]  coef_bank
);
  wire       wr  = psel & penable & pready & pwrite;
  wire [3:0] sum = {1'b0, pwdata[2:0]} + {1'b0, pwdata[6:4]};
  wire       bad = (pwdata[2:0] == 3'h0) || (pwdata[6:4] > pwdata[2:0]) || (sum > 4'h4);
  reg  [7:0] sel_r;
  reg        ll_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 8'hFF;
      ll_r  <= 1'b0;
    end else if (wr && paddr == 8'h0C) begin
      sel_r <= pwdata[15:8];
    end else if (wr && paddr == 8'h14) begin
      ll_r <= pwdata[1];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_answer; pready ##1 !pready; endsequence
  sequence s_adc_wait; (!adc_start) [*3]; endsequence
  property p_answer; psel && !penable |=> s_answer; endproperty
  property p_sync_pulse; sync_out |=> !sync_out; endproperty
  property p_sync_sel; sync_out |-> sel_r < 8'h04 || $past(sel_r) < 8'h04; endproperty
  property p_split_bad; wr && paddr == 8'h00 && bad |-> pslverr; endproperty
  property p_split_ok; wr && paddr == 8'h00 && !bad |-> !pslverr; endproperty
  property p_adc_wait; adc_start |=> s_adc_wait; endproperty
  property p_bank; coef_bank[1:0] != 2'h3 && coef_bank[3:2] != 2'h3; endproperty
  property p_light; coef_bank[1:0] == 2'h2 |-> ll_r || $past(ll_r); endproperty
  a_answer: assert property (p_answer) else $error("pready not one cycle");
  a_sync_pulse: assert property (p_sync_pulse) else $error("long sync pulse");
  a_sync_sel: assert property (p_sync_sel) else $error("sync out while off");
  a_split_bad: assert property (p_split_bad) else $error("bad split taken");
  a_split_ok: assert property (p_split_ok) else $error("good split refused");
  a_adc_wait: assert property (p_adc_wait) else $error("adc request early");
  a_bank: assert property (p_bank) else $error("illegal bank");
  a_light: assert property (p_light) else $error("light bank not enabled");
endmodule // phase_mgr_asserts
bind multiphase_pwm_phase_manager phase_mgr_asserts u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .sync_out, .adc_start, .coef_bank);

// ==== sim/phase_mgr_adc_model.sv ====
`timescale 1ns/1ps
module phase_mgr_adc_model (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         adc_start,
  input  wire  [1:0]  adc_chan,
  input  wire  [11:0] level,
  output logic        adc_valid,
  output logic [11:0] adc_data
);
  logic [1:0] cnt_r;
  // Each channel converted in turn, answer four cycles after the request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= 2'h0;
      adc_valid <= 1'b0;
      adc_data  <= 12'h000;
    end else begin
      adc_valid <= 1'b0;
      adc_data  <= ~adc_data;
      if (adc_start) begin
        cnt_r <= 2'h3;
      end else if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
        if (cnt_r == 2'h1) begin
          adc_valid <= 1'b1;
          adc_data  <= level;
        end
      end
    end
  end
endmodule // phase_mgr_adc_model

// ==== sim/multiphase_pwm_phase_manager_bench.sv ====
`timescale 1ns/1ps
module multiphase_pwm_phase_manager_bench;
  logic        pclk    = 0;
  logic        presetn = 0;
  logic        psel    = 0;
  logic        penable = 0;
  logic        pwrite  = 0;
  logic [7:0]  paddr   = 0;
  logic [31:0] pwdata  = 0;
  logic        sync_in = 0;
  logic [11:0] level   = 12'h064;
  wire  [31:0] prdata;
  wire         pready, pslverr, sync_out, adc_start, adc_valid;
  wire  [3:0]  pulse_output, coef_bank;
  wire  [1:0]  adc_chan;
  wire  [11:0] adc_data;
  wire  [17:0] fast_oc_thresh;
  wire  [4:0]  obs = {pulse_output, sync_out};
  logic [31:0] rdat;
  logic        rerr;
  int          fails = 0, n_tests = 0, n_rise = 0, n;
  time         t_a = 0, t_s = 0, gap = 0, t0, t1;
  always #50 pclk = ~pclk;
  multiphase_pwm_phase_manager dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sync_in, .sync_out, .pulse_output, .adc_start,
    .adc_chan, .adc_valid, .adc_data, .coef_bank, .fast_oc_thresh);
  phase_mgr_adc_model adc (.pclk, .presetn, .adc_start, .adc_chan, .level, .adc_valid,
    .adc_data);
  always @(posedge pulse_output[0]) n_rise++;
  // Slot spacing from first request of each burst
  always @(posedge adc_start) begin
    if ($time - t_a > 50000) begin
      gap = $time - t_s;
      t_s = $time;
    end
    t_a = $time;
  end
  task report_and_stop;
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_in(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if (!(g >= lo && g <= hi)) begin
      fails++;
      $display("MISMATCH %0t %h out of range", $time, g);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask
  task rise(input int k, output time t);
    wait (pulse_output[k] === 1'b0);
    wait (pulse_output[k] === 1'b1);
    t = $time;
  endtask
  task meas(input int k, input int e);
    rise(0, t0);
    rise(k, t1);
    chk(32'((t1 - t0) / 100), e);
  endtask
  task count(input int k);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      if (obs[k] === 1'b1) n++;
    end
  endtask
  task t_regs;
    chk(fast_oc_thresh, 32'h0003_FFFF);
    apb(8'h24, 1, 32'h0001_2345);
    cyc(1);
    chk(fast_oc_thresh, 32'h0001_2345);
    apb(8'h00, 0, 0);
    chk(rdat, 32'h0000_0004);
    apb(8'h0C, 0, 0);
    chk(rdat, 32'h0000_FF00);
    apb(8'h3C, 0, 0);
    chk(rerr, 1);
    chk(rdat, 0);
  endtask
  task t_split;
    logic [31:0] last, w;
    logic        e;
    last = 4;
    for (int a = 0; a < 5; a++) begin
      for (int b = 0; b < 5; b++) begin
        w = (b << 4) | a;
        e = (a == 0) || (b > a) || (a + b > 4);
        apb(8'h00, 1, w);
        chk(rerr, e);
        if (!e) last = w;
        apb(8'h00, 0, 0);
        chk(rdat, last);
      end
    end
    apb(8'h00, 1, 4);
  endtask
  task t_spread;
    cyc(300);
    meas(1, 25);
    meas(3, 75);
    apb(8'h00, 1, 32'h0000_0022);
    cyc(300);
    meas(1, 50);
    meas(2, 23);
    meas(3, 73);
    apb(8'h00, 1, 4);
  endtask
  task t_sync_out;
    for (int c = 0; c < 5; c++) begin
      apb(8'h0C, 1, c << 8);
      cyc(100);
      count(0);
      chk(n, c < 4 ? 2 : 0);
    end
  endtask
  task sync_run(input int m, input int per, input int k, input int e);
    apb(8'h0C, 1, 32'h0000_FF00 | m);
    for (int i = 0; i < k + 3; i++) begin
      if (i == 3) n_rise = 0;
      @(posedge pclk);
      sync_in <= 1;
      @(posedge pclk);
      sync_in <= 0;
      cyc(per - 2);
    end
    chk(n_rise, e);
  endtask
  task t_sync_in;
    sync_run(1, 80, 5, 5);
    sync_run(1, 150, 2, 4);
    sync_run(2, 80, 5, 4);
    apb(8'h2C, 0, 0);
    chk(rdat[4], 1);
    apb(8'h34, 1, 1);
    apb(8'h2C, 0, 0);
    chk(rdat[4], 0);
  endtask
  task t_current;
    apb(8'h1C, 1, 32'h2020_2020);
    cyc(32000);
    apb(8'h30, 0, 0);
    chk_in(rdat[15:0], 776, 800);
    chk(gap, 200000);
    chk(coef_bank[1:0], 1);
    apb(8'h10, 1, 32'h07D0_0384);
    apb(8'h14, 1, 32'h0000_0007);
    cyc(4000);
    apb(8'h2C, 0, 0);
    chk(rdat[2], 1);
    chk(coef_bank[1:0], 2);
    count(4);
    chk(n, 0);
    apb(8'h10, 1, 32'h0064_0032);
    cyc(4000);
    apb(8'h2C, 0, 0);
    chk(rdat[2], 0);
    chk(coef_bank[1:0], 1);
    count(4);
    chk(n, 64);
    apb(8'h18, 1, 32'h0000_012C);
    cyc(4000);
    apb(8'h2C, 0, 0);
    chk(rdat[0], 1);
    count(1);
    chk(n, 0);
  endtask
  initial begin
    cyc(4);
    presetn <= 1;
    t_regs;
    t_split;
    t_spread;
    t_sync_out;
    t_sync_in;
    t_current;
    report_and_stop;
  end
  initial begin
    #8_000_000;
    fails++;
    report_and_stop;
  end
endmodule // multiphase_pwm_phase_manager_bench
